// *** rtl/share_supply_pkg.sv ***
// Constants and types of the share bus and supply-on configuration bank
package share_supply_pkg;

  // Register offsets
  localparam logic [7:0] OFS_SHARE_BW   = 8'h29;
  localparam logic [7:0] OFS_SHARE_SET  = 8'h2A;
  localparam logic [7:0] OFS_TEMP_TRIM  = 8'h2B;
  localparam logic [7:0] OFS_SUPPLY_ON  = 8'h2C;
  localparam logic [7:0] OFS_STATUS     = 8'h2D;

  // Reset values
  localparam logic [7:0] RST_SHARE_BW   = 8'h00;
  localparam logic [7:0] RST_SHARE_SET  = 8'h00;
  localparam logic [7:0] RST_TEMP_TRIM  = 8'h00;
  localparam logic [7:0] RST_SUPPLY_ON  = 8'h00;

  // Field positions, share bus bandwidth register
  localparam int BW_STREAM_BIT = 4;
  localparam int BW_SRC_BIT    = 3;
  localparam int BW_LSB        = 0;
  localparam int BW_W          = 3;
  // Field positions, share bus setting register
  localparam int SET_DROP_LSB  = 4;
  localparam int SET_TOL_LSB   = 0;
  localparam int SET_FIELD_W   = 4;
  // Field positions, temperature gain trim register
  localparam int TRIM_POL_BIT  = 4;
  localparam int TRIM_MAG_LSB  = 0;
  localparam int TRIM_MAG_W    = 4;
  // Field positions, supply-on register
  localparam int SON_SRC_LSB   = 6;
  localparam int SON_SW_BIT    = 5;
  localparam int SON_DLY_LSB   = 3;
  // Status register bit positions
  localparam int STS_SUPPLY_BIT = 0;
  localparam int STS_GO_BIT     = 1;
  localparam int STS_MATCH_BIT  = 2;
  localparam int STS_DATA_BIT   = 3;

  // Gain trim scale: full code 15/128 is about 12 percent
  localparam int TRIM_SHIFT    = 7;

  // Timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int DLY_HALF_MS   = 500;
  localparam int DLY_ONE_MS    = 1000;
  localparam int DLY_TWO_MS    = 2000;
  localparam int DLY_HALF_CYC  = (CLK_HZ / 1000) * DLY_HALF_MS;
  localparam int DLY_ONE_CYC   = (CLK_HZ / 1000) * DLY_ONE_MS;
  localparam int DLY_TWO_CYC   = (CLK_HZ / 1000) * DLY_TWO_MS;

  // Supply-on source selection
  typedef enum logic [1:0] {
    SRC_ALWAYS = 2'b00,
    SRC_PIN    = 2'b01,
    SRC_SOFT   = 2'b10,
    SRC_BOTH   = 2'b11
  } supply_src_e;

  // Supply-on sequencer
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_WAIT = 2'b01,
    ST_ON   = 2'b10
  } supply_st_e;

endpackage

// *** rtl/share_supply_cfg.sv ***
// Share bus, temperature trim and supply-on configuration bank with sample FIFO
`timescale 1ns/1ps

// Sample FIFO with registered flags
module share_sample_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output      logic         o_in_ready,
  // Drain side
  output      logic [W-1:0] o_out_data,
  output      logic         o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("share_sample_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
    logic                    in_ready;
    logic                    out_valid;
  } fifo_s;

  fifo_s q_r;
  fifo_s q_nxt;
  logic  push;
  logic  pop;

  assign push        = i_in_valid & q_r.in_ready;
  assign pop         = q_r.out_valid & i_out_ready;
  assign o_in_ready  = q_r.in_ready;
  assign o_out_valid = q_r.out_valid;
  assign o_out_data  = q_r.mem[q_r.rd];

  // Flags are computed ahead so both ports come from flops
  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wr] = i_in_data;
      q_nxt.wr          = q_r.wr + 1'b1;
    end
    if (pop) begin
      q_nxt.rd = q_r.rd + 1'b1;
    end
    q_nxt.cnt       = q_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    q_nxt.in_ready  = (q_nxt.cnt != (AW+1)'(DEPTH));
    q_nxt.out_valid = (q_nxt.cnt != '0);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r          <= '0;
      q_r.in_ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// Functional notes
// - Stream bit 1 sends sense bit stream to share pin, 0 sends digital bus.
// - Source bit 1 picks first current sense input, 0 picks the second.
// - Three-bit bandwidth code, 000 lowest to 111 highest share loop rate.
// - Four-bit field sets how far a share master lowers its setpoint.
// - Four-bit tolerance; larger code accepts wider slave-to-master current difference.
// - Trim polarity 1 applies negative gain correction, 0 applies positive.
// - Four-bit trim magnitude scales temperature reading, about plus/minus twelve percent.
// - Source code 01 follows only the hardware supply-on pin.
// - Source code 10 follows only the software bit at bit 5.
// - Source code 11 enables only when software bit AND pin are both set.
// - After control asserts, wait 0, 0.5, 1 or 2 s before soft start.
module share_supply_cfg
  import share_supply_pkg::*;
#(
  parameter int W              = 12,
  parameter int FIFO_DEPTH     = 8,
  parameter int P_DLY_HALF_CYC = DLY_HALF_CYC,
  parameter int P_DLY_ONE_CYC  = DLY_ONE_CYC,
  parameter int P_DLY_TWO_CYC  = DLY_TWO_CYC
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Register port
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic [7:0]       i_reg_wdata,
  output      logic [7:0]       o_reg_rdata,
  // Current sense conversion results
  input  wire logic [W-1:0]     i_first_current_sense_input,
  input  wire logic [W-1:0]     i_second_current_sense_input,
  input  wire logic             i_cs_valid,
  output      logic             o_cs_ready,
  // Share bus
  input  wire logic             i_share_bus_digital,
  input  wire logic [W-1:0]     i_share_bus_value,
  input  wire logic             i_is_master,
  output      logic             o_share_output_pin,
  output      logic [3:0]       o_setpoint_drop,
  output      logic             o_share_match,
  // Temperature sensor
  input  wire logic [11:0]      i_temperature_sensor_raw,
  input  wire logic             i_temperature_sensor_valid,
  output      logic [11:0]      o_temperature_corrected,
  output      logic             o_temperature_valid,
  // Supply on
  input  wire logic             i_supply_on_pin,
  output      logic             o_supply_on_control,
  output      logic             o_soft_start_go
);

  // Refuse widths and counts the logic cannot hold
  if (W < 4 || W > 16 || P_DLY_HALF_CYC < 1 || P_DLY_ONE_CYC < 1 || P_DLY_TWO_CYC < 1)
  begin : g_bad_param
    $error("share_supply_cfg: unsupported parameter value");
  end

  typedef struct packed {
    logic [7:0]   bw;
    logic [7:0]   set;
    logic [7:0]   trim;
    logic [7:0]   son;
    logic [7:0]   rdata;
    logic [W-1:0] sample;
    logic [W:0]   acc;
    logic         share_pin;
    logic [7:0]   tick;
    logic [3:0]   drop;
    logic         match;
    logic [11:0]  temp;
    logic         temp_v;
    supply_st_e   st;
    logic [31:0]  dly;
    logic         son_ctl;
    logic         go;
  } cfg_s;

  cfg_s         q_r;
  cfg_s         q_nxt;
  logic [W-1:0] fifo_data;
  logic         fifo_valid;
  logic         pop;
  logic         ctl;
  logic [W-1:0] diff;
  logic [15:0]  prod;
  logic [12:0]  adj;
  logic [12:0]  sum;
  logic [4:0]   hit;

  // One decode serves both the write strobe and the read mux
  function automatic logic [4:0] reg_hit(input logic [7:0] a);
    reg_hit = 5'h00;
    if (a == OFS_SHARE_BW) begin
      reg_hit[0] = 1'b1;
    end else if (a == OFS_SHARE_SET) begin
      reg_hit[1] = 1'b1;
    end else if (a == OFS_TEMP_TRIM) begin
      reg_hit[2] = 1'b1;
    end else if (a == OFS_SUPPLY_ON) begin
      reg_hit[3] = 1'b1;
    end else if (a == OFS_STATUS) begin
      reg_hit[4] = 1'b1;
    end
  endfunction

  // Decoded address; at most one bit set, status is never written
  assign hit = reg_hit(i_reg_addr);

  // Source picks which sense reading is buffered
  share_sample_fifo #(
    .W     (W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_data   (q_r.bw[BW_SRC_BIT] ? i_first_current_sense_input
                                     : i_second_current_sense_input),
    .i_in_valid  (i_cs_valid),
    .o_in_ready  (o_cs_ready),
    .o_out_data  (fifo_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop)
  );

  // Sample taken once per bandwidth tick; low code drains slowly
  assign pop = fifo_valid & (q_r.tick == 8'h00);

  // Combined supply-on condition, live each cycle
  always_comb begin
    case (supply_src_e'(q_r.son[SON_SRC_LSB +: 2]))
      SRC_ALWAYS: ctl = 1'b1;
      SRC_PIN:    ctl = i_supply_on_pin;
      SRC_SOFT:   ctl = q_r.son[SON_SW_BIT];
      SRC_BOTH:   ctl = q_r.son[SON_SW_BIT] & i_supply_on_pin;
      default:    ctl = 1'b0;
    endcase
  end

  // Magnitude of share error and trim adjustment
  assign diff = (q_r.sample >= i_share_bus_value) ? q_r.sample - i_share_bus_value
                                                  : i_share_bus_value - q_r.sample;
  assign prod = i_temperature_sensor_raw * q_r.trim[TRIM_MAG_LSB +: TRIM_MAG_W];
  assign adj  = {4'h0, prod[TRIM_SHIFT +: 9]};
  assign sum  = q_r.trim[TRIM_POL_BIT] ? {1'b0, i_temperature_sensor_raw} - adj
                                       : {1'b0, i_temperature_sensor_raw} + adj;

  // Next-state logic
  always_comb begin
    q_nxt = q_r;

    // Register writes; reserved bits are stored as written
    if (i_reg_wr) begin
      if (hit[0]) begin
        q_nxt.bw = i_reg_wdata;
      end else if (hit[1]) begin
        q_nxt.set = i_reg_wdata;
      end else if (hit[2]) begin
        q_nxt.trim = i_reg_wdata;
      end else if (hit[3]) begin
        q_nxt.son = i_reg_wdata;
      end
    end

    // Read data, one cycle after the address; unmapped reads zero
    if (hit[0]) begin
      q_nxt.rdata = q_r.bw;
    end else if (hit[1]) begin
      q_nxt.rdata = q_r.set;
    end else if (hit[2]) begin
      q_nxt.rdata = q_r.trim;
    end else if (hit[3]) begin
      q_nxt.rdata = q_r.son;
    end else if (hit[4]) begin
      q_nxt.rdata                 = 8'h00;
      q_nxt.rdata[STS_SUPPLY_BIT] = q_r.son_ctl;
      q_nxt.rdata[STS_GO_BIT]     = q_r.go;
      q_nxt.rdata[STS_MATCH_BIT]  = q_r.match;
      q_nxt.rdata[STS_DATA_BIT]   = fifo_valid;
    end else begin
      q_nxt.rdata = 8'h00;
    end

    // Bandwidth tick: period 2^(7-code) cycles, code 111 every cycle
    if (q_r.tick == 8'h00) begin
      q_nxt.tick = 8'((9'h080 >> q_r.bw[BW_LSB +: BW_W]) - 9'h001);
    end else begin
      q_nxt.tick = q_r.tick - 8'h01;
    end
    if (pop) begin
      q_nxt.sample = fifo_data;
    end

    // First-order modulator; carry is the stream bit
    q_nxt.acc = {1'b0, q_r.acc[W-1:0]} + {1'b0, q_r.sample};
    q_nxt.share_pin = q_r.bw[BW_STREAM_BIT] ? q_nxt.acc[W] : i_share_bus_digital;

    // Master lowers its setpoint; slave checks its tolerance
    q_nxt.drop  = i_is_master ? q_r.set[SET_DROP_LSB +: SET_FIELD_W] : 4'h0;
    q_nxt.match = diff <= W'(q_r.set[SET_TOL_LSB +: SET_FIELD_W]);

    // Trimmed temperature, saturated at both ends
    q_nxt.temp_v = i_temperature_sensor_valid;
    if (i_temperature_sensor_valid) begin
      if (sum[12]) begin
        q_nxt.temp = q_r.trim[TRIM_POL_BIT] ? 12'h000 : 12'hFFF;
      end else begin
        q_nxt.temp = sum[11:0];
      end
    end

    // Supply sequencer; dropping control ends any wait at once
    q_nxt.son_ctl = ctl;
    case (q_r.st)
      ST_OFF: begin
        if (ctl) begin
          case (q_r.son[SON_DLY_LSB +: 2])
            2'b00:   q_nxt.dly = 32'h0000_0000;
            2'b01:   q_nxt.dly = 32'(P_DLY_HALF_CYC);
            2'b10:   q_nxt.dly = 32'(P_DLY_ONE_CYC);
            default: q_nxt.dly = 32'(P_DLY_TWO_CYC);
          endcase
          q_nxt.st = (q_r.son[SON_DLY_LSB +: 2] == 2'b00) ? ST_ON : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!ctl) begin
          q_nxt.st = ST_OFF;
        end else if (q_r.dly <= 32'h0000_0001) begin
          q_nxt.st = ST_ON;
        end else begin
          q_nxt.dly = q_r.dly - 32'h0000_0001;
        end
      end
      ST_ON: begin
        if (!ctl) begin
          q_nxt.st = ST_OFF;
        end
      end
      default: q_nxt.st = ST_OFF;
    endcase
    q_nxt.go = (q_nxt.st == ST_ON);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r      <= '0;
      q_r.bw   <= RST_SHARE_BW;
      q_r.set  <= RST_SHARE_SET;
      q_r.trim <= RST_TEMP_TRIM;
      q_r.son  <= RST_SUPPLY_ON;
      q_r.st   <= ST_OFF;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from flops
  assign o_reg_rdata             = q_r.rdata;
  assign o_share_output_pin      = q_r.share_pin;
  assign o_setpoint_drop         = q_r.drop;
  assign o_share_match           = q_r.match;
  assign o_temperature_corrected = q_r.temp;
  assign o_temperature_valid     = q_r.temp_v;
  assign o_supply_on_control     = q_r.son_ctl;
  assign o_soft_start_go         = q_r.go;

endmodule

// *** sim/share_supply_cfg_assertions.sv ***
// Checker of supply-on, share pin, drop and trim behaviour at the ports
`timescale 1ns/1ps
module share_supply_chk
  import share_supply_pkg::*;
(
  // Clock, reset and register port
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_wdata,
  // Watched pins
  input wire logic        i_share_bus_digital,
  input wire logic        i_is_master,
  input wire logic        i_supply_on_pin,
  input wire logic        i_temperature_sensor_valid,
  input wire logic [11:0] i_temperature_sensor_raw,
  input wire logic        o_share_output_pin,
  input wire logic [3:0]  o_setpoint_drop,
  input wire logic [11:0] o_temperature_corrected,
  input wire logic        o_temperature_valid,
  input wire logic        o_supply_on_control,
  input wire logic        o_soft_start_go
);
  logic [7:0] bw_r, set_r, trim_r, son_r;
  // Shadow copies of the writable registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {bw_r, set_r, trim_r, son_r} <= '0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == OFS_SHARE_BW) bw_r <= i_reg_wdata;
      if (i_reg_addr == OFS_SHARE_SET) set_r <= i_reg_wdata;
      if (i_reg_addr == OFS_TEMP_TRIM) trim_r <= i_reg_wdata;
      if (i_reg_addr == OFS_SUPPLY_ON) son_r <= i_reg_wdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Delay code 01; the bound suits a half delay of 8 to 27 cycles, such as 10
  sequence s_wait_arm;
    $rose(o_supply_on_control) && son_r[4:3] == 2'b01;
  endsequence
  sequence s_wait_run;
    (!o_soft_start_go) [*8] ##[1:20] (o_soft_start_go || !o_supply_on_control);
  endsequence
  a_src_always: assert property (son_r[7:6] == 2'b00 |=> o_supply_on_control)
    else $error("control low with source always");
  a_src_pin: assert property (son_r[7:6] == 2'b01 |=>
    o_supply_on_control == $past(i_supply_on_pin))
    else $error("control does not follow pin");
  a_src_soft: assert property (son_r[7:6] == 2'b10 |=>
    o_supply_on_control == $past(son_r[5]))
    else $error("control does not follow software bit");
  a_src_both: assert property (son_r[7:6] == 2'b11 |=>
    o_supply_on_control == $past(son_r[5] & i_supply_on_pin))
    else $error("control is not the and of bit and pin");
  a_go_now: assert property ($rose(o_supply_on_control) && son_r[4:3] == 2'b00 |->
    o_soft_start_go)
    else $error("go late with zero delay");
  a_go_wait: assert property (s_wait_arm |-> s_wait_run)
    else $error("go wrong with half delay");
  // Go falls with control at one edge, so only the same-cycle pairing is fixed
  a_go_drop: assert property (!o_supply_on_control |-> !o_soft_start_go)
    else $error("go kept without control");
  a_bus_copy: assert property (!bw_r[4] |=>
    o_share_output_pin == $past(i_share_bus_digital))
    else $error("share pin is not the bus signal");
  a_drop_field: assert property (1 |=>
    o_setpoint_drop == ($past(i_is_master) ? $past(set_r[7:4]) : 4'h0))
    else $error("setpoint drop wrong");
  a_trim_zero: assert property (i_temperature_sensor_valid && trim_r[3:0] == 4'h0 |=>
    o_temperature_valid && o_temperature_corrected == $past(i_temperature_sensor_raw))
    else $error("zero trim changed the reading");
  // Polarity is the one in force when the reading was taken
  a_trim_sign: assert property (i_temperature_sensor_valid |=>
    ($past(trim_r[4]) ? o_temperature_corrected <= $past(i_temperature_sensor_raw)
                      : o_temperature_corrected >= $past(i_temperature_sensor_raw)))
    else $error("trim moved the wrong way");
endmodule

bind share_supply_cfg share_supply_chk chk_u (.i_clk, .i_rst, .i_reg_addr, .i_reg_wr,
  .i_reg_wdata, .i_share_bus_digital, .i_is_master, .i_supply_on_pin,
  .i_temperature_sensor_valid, .i_temperature_sensor_raw, .o_share_output_pin,
  .o_setpoint_drop, .o_temperature_corrected, .o_temperature_valid,
  .o_supply_on_control, .o_soft_start_go);

// *** sim/share_partner.sv ***
// Model of the parallel supplies on the share bus
`timescale 1ns/1ps
module share_partner #(
  parameter int W = 12
) (
  // Clock and bus level asked by the bench
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_level,
  // Share bus as seen by the block
  output      logic         o_digital,
  output      logic [W-1:0] o_value
);
  logic [1:0] step_r = 2'h0;
  // Bus bit changes often, so a stuck copy on the pin shows
  always @(negedge i_clk) begin
    step_r <= step_r + 2'h1;
  end
  assign o_digital = step_r[0] ^ step_r[1];
  assign o_value   = i_level;
endmodule

// *** sim/test_share_supply_cfg.sv ***
// Self-checking bench of the share bus and supply-on configuration bank
`timescale 1ns/1ps
module test_share_supply_cfg;
  import share_supply_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, cs_valid = 1'b0;
  logic        master = 1'b0, t_valid = 1'b0, son_pin = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [11:0] first = 12'h000, second = 12'h000, level = 12'h000, raw = 12'h000;
  logic [11:0] bus_val, t_out;
  logic [3:0]  drop;
  logic        cs_ready, dig, pin_out, match, t_ok, ctl, go;
  int          fails = 0, tests_run = 0;
  // Short delays keep the sequencer waits to tens of cycles
  share_supply_cfg #(.P_DLY_HALF_CYC(10), .P_DLY_ONE_CYC(20), .P_DLY_TWO_CYC(40)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_first_current_sense_input(first),
    .i_second_current_sense_input(second), .i_cs_valid(cs_valid), .o_cs_ready(cs_ready),
    .i_share_bus_digital(dig), .i_share_bus_value(bus_val), .i_is_master(master),
    .o_share_output_pin(pin_out), .o_setpoint_drop(drop), .o_share_match(match),
    .i_temperature_sensor_raw(raw), .i_temperature_sensor_valid(t_valid),
    .o_temperature_corrected(t_out), .o_temperature_valid(t_ok),
    .i_supply_on_pin(son_pin), .o_supply_on_control(ctl), .o_soft_start_go(go));
  share_partner #(.W(12)) far_u (.i_clk(clk), .i_level(level), .o_digital(dig),
    .o_value(bus_val));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Write strobe drops a full cycle before the next write
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    tick(1);
    chk(rdata, e);
  endtask
  task automatic t_regs();
    logic [7:0] v [4] = '{8'hC7, 8'h5A, 8'h1F, 8'h00};
    for (int i = 0; i < 4; i++) begin
      rchk(8'(OFS_SHARE_BW + i), 8'h00);
      wreg(8'(OFS_SHARE_BW + i), v[i]);
      rchk(8'(OFS_SHARE_BW + i), v[i]);
    end
    wreg(8'h30, 8'hFF);
    rchk(8'h30, 8'h00);
  endtask
  task automatic t_supply();
    logic e;
    for (int c = 0; c < 16; c++) begin
      son_pin = c[0];
      wreg(8'h2C, {c[3:2], c[1], 5'h00});
      tick(1);
      e = c[3:2] == 0 | (c[3:2] == 1 & c[0]) | (c[3:2] == 2 & c[1]) |
          (c[3:2] == 3 & c[1] & c[0]);
      chk(ctl, e);
    end
  endtask
  task automatic t_delay();
    int n [4] = '{0, 10, 20, 40};
    int k;
    for (int d = 0; d < 4; d++) begin
      son_pin = 1'b0;
      wreg(8'h2C, {3'b010, d[1:0], 3'h0});
      tick(2);
      chk(go, 1'b0);
      son_pin = 1'b1;
      k = 0;
      while (go !== 1'b1 && k < 100) begin
        tick(1);
        k++;
      end
      chk(k >= n[d] + 1 && k <= n[d] + 3, 1'b1);
    end
  endtask
  // Full-scale first input against zero second input shows which one streams
  task automatic t_stream();
    logic d;
    int ones;
    first = 12'hFFF;
    cs_valid = 1'b1;
    for (int s = 0; s < 2; s++) begin
      wreg(8'h29, {4'h1, s[0], 3'h7});
      tick(10);
      ones = 0;
      repeat (64) begin
        ones += pin_out;
        tick(1);
      end
      chk(s ? ones > 56 : ones == 0, 1'b1);
    end
    cs_valid = 1'b0;
    wreg(8'h29, 8'h07);
    // The model moves the bus bit at the falling edge, so take it at the rising one
    repeat (20) begin
      @(posedge clk);
      d = dig;
      tick(1);
      chk(pin_out, d);
    end
  endtask
  // Slowest drain acts as the stalled far side while the buffer fills
  task automatic t_fifo();
    int n = 0;
    chk(cs_ready, 1'b1);
    wreg(8'h29, 8'h08);
    first = 12'h100;
    cs_valid = 1'b1;
    repeat (12) begin
      n += cs_ready;
      tick(1);
    end
    cs_valid = 1'b0;
    chk(n >= 8 && n <= 9, 1'b1);
    wreg(8'h29, 8'h0F);
    // The slow period already counting runs out before the fast code applies
    tick(140);
    chk(cs_ready, 1'b1);
  endtask
  task automatic t_share();
    level = 12'h104;
    master = 1'b1;
    wreg(8'h2A, 8'h53);
    tick(2);
    chk(match, 1'b0);
    chk(drop, 4'h5);
    wreg(8'h2A, 8'h54);
    master = 1'b0;
    tick(2);
    chk(match, 1'b1);
    chk(drop, 4'h0);
    // Status: control and go still up from the delay test, match set, buffer empty
    rchk(OFS_STATUS, 8'h07);
  endtask
  task automatic t_temp();
    logic [7:0] tr [3] = '{8'h0F, 8'h1F, 8'h00};
    logic [11:0] ex [3] = '{12'h478, 12'h388, 12'h400};
    raw = 12'h400;
    for (int i = 0; i < 3; i++) begin
      wreg(8'h2B, tr[i]);
      t_valid = 1'b1;
      tick(1);
      t_valid = 1'b0;
      chk(t_ok, 1'b1);
      chk(t_out, ex[i]);
      tick(1);
    end
  endtask
  initial begin
    tick(5);
    rst = 1'b0;
    tick(1);
    chk(ctl, 1'b1);
    t_regs();
    t_supply();
    t_delay();
    t_stream();
    t_fifo();
    t_share();
    t_temp();
    results();
  end
  // Sequence needs under 2000 cycles; this allows 5000
  initial begin
    #200000;
    fails++;
    results();
  end
endmodule
